//--- design/instruction_word_decode.sv
// instruction fetch, field decode and effective address formation
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
// Notes on behaviour
// - instruction-cycle words decode, others are data
// - counter advances each fetch; branch overwrites it
// - 16-bit words, position 0 most significant
// - negatives in two's complement, sign at 0
// - single word spans -32768 to 32767
// - double: high word even, low word odd
// - format bit 0 one word, 1 two words
// - five-bit opcode, 26 valid codes
// - displacement added to tag-chosen register
// - displacement sign is word bit 8
// - tag picks base; two-word adds index
// - two-word address is whole second word
// - indirect bit, except modify_index_skip tag 00
// - branch_out_flag on cond_branch_skip returns
// - six condition bits pick tested indicators
// - power-on reset clears control and registers
// - after reset clock stops, phases keep running
// - reset key zeroes counter, keeps index registers
// - storage address from address reg or channel
// - read word held; write-back from hold register
// - start reads location 0 into control fields
// - cycle start copies counter, then increments
// - modifier holds indirect bit 8, branch-out 9
module instruction_word_decode
  import iwd_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int MC_HALF = HALF_CYC
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite register port
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // core storage
  output logic [15:0]            stor_addr,
  output logic                   stor_rd,
  input  wire logic [15:0]       stor_rdata,
  output logic                   stor_wr,
  output logic [15:0]            stor_wdata,
  // data channel
  input  wire logic              chan_req,
  input  wire logic [15:0]       chan_addr,
  input  wire logic              chan_wr,
  input  wire logic [15:0]       chan_wdata,
  output logic                   chan_ack,
  // indicators, results and oscillator phases
  input  wire logic [5:0]        status_ind,
  output logic                   irq_return,
  output logic [31:0]            data_word,
  output logic                   data_valid,
  output logic                   osc_phase_a,
  output logic                   osc_phase_b
);
  logic [15:0] osc_q;
  logic        ph_sel_q;
  logic        run_q;
  logic        act_q;
  logic        chan_q;
  logic        decide_q;
  kind_t       kind_q;
  instr_t      ir_q;
  logic [15:0] seq_q;
  logic [15:0] xr_q [3];
  logic [15:0] ea_q;
  logic [15:0] hold_q;
  logic [15:0] hi_q;
  logic        bad_op_q;

  // oscillator runs free; the machine cycle only while running
  wire tick    = (osc_q == 16'(MC_HALF - 1));
  wire tick_a  = tick & ~ph_sel_q;
  wire tick_b  = tick & ph_sel_q;
  wire start_c = tick_a & run_q & ~act_q & ~decide_q;

  // bus decode
  wire wr_go = s_axi_awready;
  wire rd_go = s_axi_arready;
  wire [7:0] wa = 8'(s_axi_awaddr);
  wire [7:0] ra = 8'(s_axi_araddr);
  wire [15:0] wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire wr_ctrl = wr_go & (wa == R_CTRL) & s_axi_wstrb[0];
  wire key_start = wr_ctrl & s_axi_wdata[CTL_START];
  wire key_stop  = wr_ctrl & s_axi_wdata[CTL_STOP];
  wire key_reset = wr_ctrl & s_axi_wdata[CTL_RKEY];
  wire wr_seq = wr_go & (wa == R_SEQ) & ~run_q;
  wire [15:0] wr_val_seq = (seq_q & ~wmask) | (s_axi_wdata[15:0] & wmask);

  // a fetch decides in the cycle hold gets the word, before ir_q has it
  wire instr_t cur = (kind_q == kind_i1) ? instr_t'(hold_q) : ir_q;
  wire        ia      = cur.disp[IA_BIT];
  wire        bo      = cur.disp[BO_BIT];
  wire [5:0]  cond    = cur.disp[5:0];
  wire        op_ok   = OP_VALID[cur.op];
  wire        op_dbl  = OP_DOUBLE[cur.op];
  wire        is_cbs  = (cur.op == OP_CBS);
  wire        mis_t0  = (cur.op == OP_MIS) & (cur.tag == TAG_SEQ);
  wire        ind_req = cur.fmt & ia & ~mis_t0;
  wire        cond_hit = |(cond & status_ind);
  wire [15:0] xr_sel  = xr_q[2'(cur.tag - 2'd1)];
  wire [15:0] base    = (cur.tag == TAG_SEQ) ? seq_q : xr_sel;
  wire [15:0] disp_x  = {{8{cur.disp[7]}}, cur.disp};
  wire [15:0] ea_one  = base + disp_x;
  wire [15:0] idx_add = (cur.tag == TAG_SEQ) ? 16'h0000 : xr_sel;
  wire [15:0] ea_two  = hold_q + idx_add;
  wire [15:0] ea_new  = (kind_q == kind_i1) ? ea_one :
                        (kind_q == kind_i2) ? ea_two : hold_q;
  wire        ind_now = ind_req & (kind_q != kind_ind);
  wire        two_pending = (kind_q == kind_i1) & cur.fmt;
  wire        ea_ready = decide_q & ~two_pending &
                         ((kind_q == kind_i1) | (kind_q == kind_i2) |
                          (kind_q == kind_ind));
  wire        do_cbs  = ea_ready & is_cbs & ~ind_now;
  wire        cbs_br  = do_cbs & cur.fmt & ~cond_hit;
  wire        cbs_skip = do_cbs & ~cur.fmt & cond_hit;

  // next cycle kind once a cycle ends
  wire kind_t after_ea = is_cbs  ? kind_i1 :
                         ind_now ? kind_ind :
                         ~op_ok  ? kind_i1 : kind_e1;
  wire kind_t kind_d =
    (kind_q == kind_i1) ? (cur.fmt ? kind_i2 : after_ea) :
    (kind_q == kind_e1) ? (op_dbl ? kind_e2 : kind_i1) :
    (kind_q == kind_e2) ? kind_i1 : after_ea;

  // storage address of the cycle being started
  wire [15:0] ea_even = {ea_q[15:1], 1'b0};
  wire [15:0] ea_odd  = {ea_q[15:1], 1'b1};
  wire fetch_kind = (kind_q == kind_i1) | (kind_q == kind_i2);
  wire [15:0] cyc_addr =
    chan_req               ? chan_addr :
    fetch_kind             ? seq_q :
    (kind_q == kind_ind)   ? ea_q :
    ~op_dbl                ? ea_q :
    (kind_q == kind_e1)    ? ea_even : ea_odd;

  // register read mux
  wire [15:0] stat_w = {10'h000, bad_op_q, kind_q, act_q, run_q};
  wire rd_hit = (ra == R_CTRL) | (ra == R_STAT) | (ra == R_SEQ) |
                (ra == R_XR1) | (ra == R_XR2) | (ra == R_XR3) |
                (ra == R_INSTR) | (ra == R_EA) | (ra == R_DATA) |
                (ra == R_HOLD);
  wire [31:0] rd_mux =
    (ra == R_CTRL)  ? {31'h0, run_q} :
    (ra == R_STAT)  ? {16'h0, stat_w} :
    (ra == R_SEQ)   ? {16'h0, seq_q} :
    (ra == R_XR1)   ? {16'h0, xr_q[0]} :
    (ra == R_XR2)   ? {16'h0, xr_q[1]} :
    (ra == R_XR3)   ? {16'h0, xr_q[2]} :
    (ra == R_INSTR) ? {16'h0, ir_q} :
    (ra == R_EA)    ? {16'h0, ea_q} :
    (ra == R_DATA)  ? data_word :
    (ra == R_HOLD)  ? {16'h0, hold_q} : 32'h0000_0000;

  // oscillator: phase pulses continue even while stopped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_q       <= 16'h0000;
      ph_sel_q    <= 1'b0;
      osc_phase_a <= 1'b0;
      osc_phase_b <= 1'b0;
    end
    else
    begin
      osc_q       <= tick ? 16'h0000 : osc_q + 16'h0001;
      ph_sel_q    <= ph_sel_q ^ tick;
      osc_phase_a <= tick_a;
      osc_phase_b <= tick_b;
    end
  end

  // run control; reset leaves the machine clock stopped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      run_q <= 1'b0;
    else if (key_stop | key_reset)
      run_q <= 1'b0;
    else if (key_start)
      run_q <= 1'b1;
  end

  // cycle sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_q    <= 1'b0;
      chan_q   <= 1'b0;
      decide_q <= 1'b0;
      kind_q   <= kind_i1;
    end
    else
    begin
      decide_q <= tick_b & act_q & ~chan_q;
      if (start_c)
      begin
        act_q  <= 1'b1;
        chan_q <= chan_req;
      end
      else if (tick_b)
        act_q <= 1'b0;
      if (key_reset)
        kind_q <= kind_i1;
      else if (decide_q)
        kind_q <= kind_d;
    end
  end

  // instruction counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seq_q <= SEQ_RESET;
    else if (key_reset)
      seq_q <= SEQ_RESET;
    else if (wr_seq)
      seq_q <= wr_val_seq;
    else if (start_c & ~chan_req & fetch_kind)
      seq_q <= seq_q + 16'h0001;
    else if (cbs_br)
      seq_q <= ea_new;
    else if (cbs_skip)
      seq_q <= seq_q + 16'h0001;
  end

  // index registers: bus loads only, the reset key leaves them
  for (genvar i = 0; i < 3; i++)
  begin : g_xr
    wire [7:0] off = R_XR1 + 8'(4 * i);
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        xr_q[i] <= 16'h0000;
      else if (wr_go & (wa == off))
        xr_q[i] <= (xr_q[i] & ~wmask) | (s_axi_wdata[15:0] & wmask);
    end
  end

  // storage side: read in the first half, write back in the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stor_addr  <= 16'h0000;
      stor_rd    <= 1'b0;
      stor_wr    <= 1'b0;
      hold_q     <= 16'h0000;
      chan_ack   <= 1'b0;
    end
    else
    begin
      stor_rd  <= start_c;
      stor_wr  <= tick_b & act_q;
      chan_ack <= tick_b & act_q & chan_q;
      if (start_c)
        stor_addr <= cyc_addr;
      if (tick_b & act_q)
        hold_q <= (chan_q & chan_wr) ? chan_wdata : stor_rdata;
    end
  end
  assign stor_wdata = hold_q;

  // fields and operands captured at the end of each machine-cycle read, channel cycles excepted
  wire cap = decide_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ir_q        <= '0;
      ea_q        <= 16'h0000;
      bad_op_q    <= 1'b0;
    end
    else if (cap)
    begin
      if (kind_q == kind_i1)
      begin
        ir_q     <= instr_t'(hold_q);
        bad_op_q <= 1'b0;
      end
      if (ea_ready)
      begin
        ea_q     <= ea_new;
        bad_op_q <= ~op_ok;
      end
    end
  end

  // data words: single-word operand, second double-word and channel read cycles deliver data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hi_q       <= 16'h0000;
      data_word  <= 32'h0000_0000;
      data_valid <= 1'b0;
      irq_return <= 1'b0;
    end
    else
    begin
      data_valid <= 1'b0;
      irq_return <= do_cbs & bo;
      if (cap & (kind_q == kind_e1) & op_dbl)
        hi_q <= hold_q;
      if (cap & (kind_q == kind_e1) & ~op_dbl)
      begin
        data_word  <= {{16{hold_q[15]}}, hold_q};
        data_valid <= 1'b1;
      end
      if (cap & (kind_q == kind_e2))
      begin
        data_word  <= {hi_q, hold_q};
        data_valid <= 1'b1;
      end
      if (tick_b & act_q & chan_q)
      begin
        data_word  <= {{16{stor_rdata[15]}}, stor_rdata};
        data_valid <= ~chan_wr;
      end
    end
  end

  // axi4-lite write channel, one transfer at a time
  wire aw_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
               ~s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end
    else
    begin
      s_axi_awready <= aw_go;
      s_axi_wready  <= aw_go;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ((wa == R_CTRL) | (wa == R_SEQ) |
                         (wa == R_XR1) | (wa == R_XR2) |
                         (wa == R_XR3)) ? RESP_OK : RESP_ERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi4-lite read channel
  wire ar_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end
    else
    begin
      s_axi_arready <= ar_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? RESP_OK : RESP_ERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- design/iwd_pkg.sv
// constants, types and register map for the instruction word decoder
`default_nettype none
package iwd_pkg;
  // machine timing
  localparam int CLK_NS   = 5;
  localparam int CYCLE_NS = 4000;
  localparam int HALF_CYC = CYCLE_NS / (2 * CLK_NS);
  // register byte offsets
  localparam logic [7:0] R_CTRL  = 8'h00;
  localparam logic [7:0] R_STAT  = 8'h04;
  localparam logic [7:0] R_SEQ   = 8'h08;
  localparam logic [7:0] R_XR1   = 8'h0c;
  localparam logic [7:0] R_XR2   = 8'h10;
  localparam logic [7:0] R_XR3   = 8'h14;
  localparam logic [7:0] R_INSTR = 8'h18;
  localparam logic [7:0] R_EA    = 8'h1c;
  localparam logic [7:0] R_DATA  = 8'h20;
  localparam logic [7:0] R_HOLD  = 8'h24;
  // control bits
  localparam int CTL_START = 0;
  localparam int CTL_STOP  = 1;
  localparam int CTL_RKEY  = 2;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  localparam logic [15:0] SEQ_RESET = 16'h0000;
  // modifier bits inside the displacement byte
  localparam int IA_BIT = 7;
  localparam int BO_BIT = 6;
  localparam logic [1:0] TAG_SEQ = 2'b00;
  // operation codes; values are arbitrary
  localparam logic [4:0] OP_CBS = 5'h09;
  localparam logic [4:0] OP_MIS = 5'h0d;
  localparam logic [31:0] OP_VALID = 32'h7dbf_bf7e;
  localparam logic [31:0] OP_DOUBLE = 32'h0000_0028;
  // instruction word, bit position 0 is the msb
  typedef struct packed {
    logic [4:0] op;
    logic       fmt;
    logic [1:0] tag;
    logic [7:0] disp;
  } instr_t;
  typedef enum logic [2:0] {
    kind_i1  = 3'b000,
    kind_i2  = 3'b001,
    kind_ind = 3'b011,
    kind_e1  = 3'b010,
    kind_e2  = 3'b110
  } kind_t;
endpackage
`default_nettype wire

//--- dv/core_store.sv
// behavioural core storage answering reads and write-backs
`default_nettype none
module core_store (
  // clock
  input  wire logic        aclk,
  // storage port
  input  wire logic [15:0] stor_addr,
  input  wire logic        stor_rd,
  output logic [15:0]      stor_rdata,
  input  wire logic        stor_wr,
  input  wire logic [15:0] stor_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic        held_q = 1'b0;
  initial stor_rdata = 16'h0000;
  // outside a read the word toggles so a late sample cannot pass
  always @(posedge aclk)
  begin
    if (stor_rd)
    begin
      stor_rdata <= mem[stor_addr[7:0]];
      held_q     <= 1'b1;
    end
    else if (!held_q)
      stor_rdata <= ~stor_rdata;
    if (stor_wr)
    begin
      mem[stor_addr[7:0]] <= stor_wdata;
      held_q              <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- dv/iwd_assertions.sv
// assertions on the decoder's storage, phase and result outputs
`default_nettype none
module iwd_assertions #(
  parameter int ADDR_W  = 8,
  parameter int MC_HALF = 4
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // storage side
  input wire logic [15:0] stor_addr,
  input wire logic        stor_rd,
  input wire logic [15:0] stor_rdata,
  input wire logic        stor_wr,
  input wire logic [15:0] stor_wdata,
  input wire logic        chan_ack,
  // results and phases
  input wire logic        irq_return,
  input wire logic        data_valid,
  input wire logic        osc_phase_a,
  input wire logic        osc_phase_b
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H  = MC_HALF;
  localparam int H1 = MC_HALF + 1;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_PHASE_AB: assert property (osc_phase_a |-> ##H osc_phase_b)
    else $error("phase b missing after phase a");
  AST_PHASE_BA: assert property (osc_phase_b |-> ##H osc_phase_a)
    else $error("phase a missing after phase b");
  AST_RD_ON_A: assert property (stor_rd |-> osc_phase_a)
    else $error("storage read outside cycle start");
  AST_ADDR_HELD: assert property (!stor_rd |-> $stable(stor_addr))
    else $error("storage address moved mid cycle");
  AST_RD_THEN_WR: assert property (stor_rd |-> ##[1:H1] stor_wr)
    else $error("no write-back after read");
  AST_WB_VALUE: assert property (
    stor_wr && !chan_ack |-> stor_wdata == stor_rdata)
    else $error("write-back differs from word read");
  AST_DATA_SRC: assert property (
    data_valid |-> (chan_ack && stor_wr) || $past(stor_wr))
    else $error("data result without storage cycle");
  AST_IRQ_SRC: assert property (
    irq_return |-> $past(stor_wr) || $past(stor_wr, 2))
    else $error("return pulse without storage cycle");
endmodule
bind instruction_word_decode iwd_assertions #(
  .ADDR_W (ADDR_W),
  .MC_HALF(MC_HALF)
) iwd_assertions_i (.*);
`default_nettype wire

//--- dv/tb.sv
// self-checking bench: register bus, program run and storage traffic
`default_nettype none
module tb
  import iwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MH = 4;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, data_word;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] stor_addr, stor_rdata, stor_wdata;
  logic [15:0] chan_addr = 0, chan_wdata = 0;
  logic        stor_rd, stor_wr, chan_req = 0, chan_wr = 0, chan_ack;
  logic        irq_return, data_valid, osc_phase_a, osc_phase_b;
  logic [5:0]  status_ind = 0;
  logic        go = 0;
  int          miscompares = 0, compares = 0, irqs = 0;
  logic [15:0] lf = 16'h0059;
  logic [15:0] aq[$];
  logic [31:0] dq[$];

  always #2.5 aclk = ~aclk;

  instruction_word_decode #(.MC_HALF(MH)) instruction_word_decode_i (.*);
  core_store core_store_i (.*);

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] sx(input logic [7:0] d);
    return {{8{d[7]}}, d};
  endfunction

  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // waits for a flag under a bound; a hang ends the run
  task automatic wt(ref logic s);
    int n = 0;
    do @(posedge aclk); while (s !== 1'b1 && ++n < 3000);
    if (n >= 3000)
    begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= 1;
    wt(s_axi_awready);
    s_axi_awvalid <= 0;
    s_axi_wvalid  <= 0;
    wt(s_axi_bvalid);
    s_axi_bready  <= 0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    s_axi_rready  <= 1;
    wt(s_axi_arready);
    s_axi_arvalid <= 0;
    wt(s_axi_rvalid);
    s_axi_rready  <= 0;
    d = s_axi_rdata;
    chk("rresp", 32'(s_axi_rresp), a > 8'h24 ? 32'h2 : 32'h0);
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    axr(a, d);
    chk("rdata", d, e);
  endtask

  always @(posedge aclk)
  begin
    if (stor_rd === 1'b1 && aq.size() > 0)
      chk("stor_addr", 32'(stor_addr), 32'(aq.pop_front()));
    else if (stor_rd === 1'b1 && !go)
      chk("idle_rd", 32'h1, 32'h0);
    if (data_valid === 1'b1 && dq.size() > 0)
      chk("data_word", data_word, dq.pop_front());
    if (irq_return === 1'b1)
      irqs++;
  end

  initial
  begin
    logic [31:0] d;
    logic [15:0] m2, m3;
    int n;
    for (int i = 0; i < 256; i++)
      core_store_i.mem[i] = 16'h0000;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdc(R_STAT, 32'h0);
    rdc(R_SEQ, 32'h0);
    rdc(8'h28, 32'h0);
    wrc(8'h28, 32'h1, RESP_ERR);
    wrc(R_STAT, 32'h1, RESP_ERR);
    $display("test reset and map done");
    wrc(R_XR1, 32'h12, RESP_OK);
    for (int i = 0; i < 2; i++)
    begin
      lf = nxt(lf);
      wrc(R_XR2 + 8'(4 * i), {16'hffff, lf}, RESP_OK);
      rdc(R_XR2 + 8'(4 * i), {16'h0, lf});
    end
    $display("test index registers done");
    lf = nxt(lf);
    m2 = lf;
    lf = nxt(lf);
    m3 = lf;
    // word layout: op, length select, register choice, displacement
    core_store_i.mem[0] = {5'h01, 1'b0, 2'b01, 8'hfe};
    core_store_i.mem[1] = {5'h03, 1'b1, 2'b01, 8'h00};
    core_store_i.mem[2] = 16'h0020;
    core_store_i.mem[3] = {5'h01, 1'b1, 2'b00, 8'h80};
    core_store_i.mem[4] = 16'h0030;
    core_store_i.mem[5] = {5'h01, 1'b0, 2'b00, 8'h7f};
    core_store_i.mem[6] = {OP_CBS, 1'b1, 2'b00, 8'h01};
    core_store_i.mem[7] = 16'h000a;
    core_store_i.mem[8'h0a] = {OP_CBS, 1'b0, 2'b00, 8'h42};
    core_store_i.mem[8'h10] = 16'h8000;
    core_store_i.mem[8'h30] = 16'h0040;
    core_store_i.mem[8'h32] = m2;
    core_store_i.mem[8'h33] = m3;
    core_store_i.mem[8'h85] = 16'h7fff;
    aq = '{16'h0, 16'h12 + sx(8'hfe), 16'h1, 16'h2, 16'h32, 16'h33,
           16'h3, 16'h4, 16'h30, 16'h40, 16'h5, 16'h6 + sx(8'h7f),
           16'h6, 16'h7, 16'ha, 16'hc};
    dq = '{32'hffff_8000, {m2, m3}, 32'h0, 32'h0000_7fff};
    status_ind <= 6'h02;
    go = 1;
    wrc(R_CTRL, 32'h1, RESP_OK);
    for (n = 0; n < 3000 && (aq.size() > 0 || irqs == 0); n++)
      @(posedge aclk);
    chk("fetches_left", 32'(aq.size()), 32'h0);
    chk("data_left", 32'(dq.size()), 32'h0);
    chk("irq_count", 32'(irqs), 32'h1);
    $display("test program run done");
    // a channel cycle steals the next machine cycle while running
    wt(osc_phase_a);
    @(posedge aclk);
    aq.push_back(16'h0030);
    dq.push_back(32'h0000_0040);
    chan_addr <= 16'h0030;
    chan_req  <= 1;
    wt(chan_ack);
    chan_req  <= 0;
    @(posedge aclk);
    chk("chan_left", 32'(aq.size() + dq.size()), 32'h0);
    $display("test data channel done");
    wrc(R_CTRL, 32'h2, RESP_OK);
    n = 0;
    do
    begin
      axr(R_STAT, d);
      n++;
    end
    while (d[0] !== 1'b0 && n < 50);
    chk("stopped", 32'(d[0]), 32'h0);
    wrc(R_SEQ, 32'h0009, RESP_OK);
    rdc(R_SEQ, 32'h9);
    wrc(R_CTRL, 32'h4, RESP_OK);
    rdc(R_SEQ, 32'(SEQ_RESET));
    rdc(R_XR1, 32'h12);
    $display("test reset key done");
    end_sim();
  end
endmodule
`default_nettype wire
